// ### hw/radar_settings_defs.vh
`ifndef RADAR_SETTINGS_DEFS_VH
`define RADAR_SETTINGS_DEFS_VH
`define OFF_SERIAL      12'h000
`define OFF_PROCESS     12'h004
`define OFF_LOOP_MIN    12'h008
`define OFF_LOOP_MAX    12'h00C
`define OFF_VEL_MIN     12'h010
`define OFF_VEL_MAX     12'h014
`define OFF_THRESH      12'h018
`define OFF_WARMUP      12'h01C
`define OFF_STATUS      12'h020
`define OFF_SMOOTH      12'h024
`define OFF_LOOP_OUT    12'h028
`define OFF_LINK        12'h02C
`define BAUD_DEFAULT    32'd9600
`define PAR_NONE        2'h0
`define PAR_ODD         2'h1
`define PAR_EVEN        2'h2
`define SERIAL_RESET    32'h0000_2580
`define PROCESS_RESET   32'h0208_0432
`define WARMUP_MS       16'd5000
`define SPAN_MAX_MMS    16'd15000
`define LOOP_MIN_UA     16'd4000
`define LOOP_MAX_UA     16'd20000
`define READING_HZ      32'd10
`define CLK_HZ          32'd100000000
`define GAIN_DEFAULT    4'h8
`endif

// ### hw/radar_settings.v
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "radar_settings_defs.vh"
module radar_settings
#(
   parameter MAX_TAPS         = 256,
   parameter CYCLES_PER_MS    = 100000,
   parameter CYCLES_PER_READ  = 10000000
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        meas_valid,
   input  wire [15:0] meas_velocity,
   input  wire        meas_incoming,
   input  wire [15:0] meas_level,
   input  wire [15:0] meas_peak,
   input  wire [15:0] meas_mean,
   input  wire        rx_byte_valid,
   input  wire [7:0]  rx_byte,
   input  wire        rx_parity,
   input  wire [7:0]  rx_addr,
   input  wire        rx_addr_valid,
   output reg         rx_byte_accept,
   output reg         answer_enable,
   output reg         tx_parity,
   input  wire [7:0]  tx_byte,
   output reg  [3:0]  amplifier_gain_cap,
   output reg  [15:0] loop_current_ua,
   output reg         loop_enable,
   output reg  [31:0] report_velocity,
   output reg         report_valid,
   output reg         report_incoming,
   output reg  [31:0] bit_rate,
   output reg         p2p_legacy_protocol,
   output reg         simple_request_response_protocol,
   output reg  [1:0]  stop_bits,
   output reg  [3:0]  peak_width,
   output reg         skip_self_config
);
   // serial: bit rate in [23:0], slave id in [31:24]
   reg  [31:0] serial_reg;
   reg  [31:0] process_reg;
   reg  [15:0] loop_min_reg;
   reg  [15:0] loop_max_reg;
   reg  [15:0] vel_min_reg;
   reg  [15:0] vel_max_reg;
   reg  [31:0] thresh_reg;
   reg  [15:0] warmup_reg;
   reg         warm_done_reg;
   reg  [31:0] ms_cnt_reg;
   reg  [15:0] ms_elapsed_reg;
   reg  [15:0] hist_mem [0:MAX_TAPS-1];
   reg  [7:0]  wr_ptr_reg;
   reg  [8:0]  fill_reg;
   reg  [31:0] sum_reg;
   reg  [31:0] smooth_reg;
   reg  [15:0] vel_acc;
   reg         acc_valid;
   reg  [7:0]  slave_id;
   reg  [2:0]  unit_sel;
   reg  [1:0]  parity_sel;
   reg  [1:0]  dir_sel;
   reg  [8:0]  taps;
   reg  [7:0]  snr_db;
   reg         snr_ok;
   reg  [15:0] old_sample;
   reg  [31:0] sum_next;
   reg  [31:0] rd_mux;
   reg  [31:0] span;
   reg  [31:0] offs;
   reg  [15:0] lo_b;
   reg  [15:0] hi_b;
   reg  [31:0] loop_scaled;
   reg  [8:0]  taps_reg;
   reg  [8:0]  avg_div;
   reg  [31:0] avg_next;
   reg         restart;
   wire        wr_en;
   wire        rd_en;

   // expected parity bit for a payload byte
   function par_bit;
      input [7:0] d;
      input [1:0] mode;
      begin
         if (mode == `PAR_ODD)
            par_bit = ^d;
         else
            par_bit = ~(^d);
      end
   endfunction

   // rough 10*log10 of ratio: 3 dB per power-of-two step
   function [7:0] log_db;
      input [15:0] num;
      input [15:0] den;
      integer i;
      reg [7:0] r;
      reg [31:0] q;
      begin
         r = 8'h00;
         q = (den == 16'h0000) ? {16'h0000, num} : ({16'h0000, num} / {16'h0000, den});
         for (i = 1; i < 16; i = i + 1)
            if (q >= (32'd1 << i))
               r = r + 8'h03;
         log_db = r;
      end
   endfunction

   // clamp limits into the instrument span
   function [15:0] clamp_span;
      input [15:0] v;
      begin
         clamp_span = (v > `SPAN_MAX_MMS) ? `SPAN_MAX_MMS : v;
      end
   endfunction

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;

   // field decode of configuration registers
   always @*
   begin
      slave_id   = serial_reg[31:24];
      parity_sel = process_reg[25:24];
      unit_sel   = process_reg[30:28];
      dir_sel    = process_reg[27:26];
      taps       = (process_reg[7:0] == 8'h00) ? 9'd1 : {1'b0, process_reg[7:0]};
      snr_db     = log_db(meas_peak, meas_mean);
      snr_ok     = snr_db >= thresh_reg[23:16];
      lo_b       = clamp_span(loop_min_reg);
      hi_b       = clamp_span(loop_max_reg);
      old_sample = hist_mem[wr_ptr_reg - taps[7:0]];
   end

   // direction, sensitivity, snr and interest window gating
   always @*
   begin
      acc_valid = meas_valid & warm_done_reg;
      if (meas_level < thresh_reg[15:0])
         acc_valid = 1'b0;
      if (!snr_ok)
         acc_valid = 1'b0;
      if (dir_sel == 2'h1 && !meas_incoming)
         acc_valid = 1'b0;
      if (dir_sel == 2'h2 && meas_incoming)
         acc_valid = 1'b0;
      if (meas_velocity < vel_min_reg || meas_velocity > vel_max_reg)
         acc_valid = 1'b0;
      vel_acc = meas_velocity;
      restart = (taps_reg != taps);
      // a new filter length starts the window over instead of mixing lengths
      if (restart)
         sum_next = {16'h0000, vel_acc};
      else if (fill_reg >= taps)
         sum_next = sum_reg + {16'h0000, vel_acc} - {16'h0000, old_sample};
      else
         sum_next = sum_reg + {16'h0000, vel_acc};
      // divide by readings held so a filling window is not pulled toward zero
      if (restart)
         avg_div = 9'h001;
      else if (fill_reg >= taps)
         avg_div = taps;
      else
         avg_div = fill_reg + 9'h001;
      avg_next = sum_next / {23'h000000, avg_div};
   end

   // apb register file; no wait states
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         serial_reg   <= `SERIAL_RESET;
         process_reg  <= `PROCESS_RESET;
         loop_min_reg <= 16'h0000;
         loop_max_reg <= `SPAN_MAX_MMS;
         vel_min_reg  <= 16'h0000;
         vel_max_reg  <= `SPAN_MAX_MMS;
         thresh_reg   <= 32'h0000_0000;
         warmup_reg   <= `WARMUP_MS;
         pready       <= 1'b0;
         pslverr      <= 1'b0;
         prdata       <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable)
         begin
            prdata  <= rd_mux;
            pslverr <= (paddr > `OFF_LINK) | (paddr[1:0] != 2'h0);
         end
         if (wr_en & pready)
         begin
            case (paddr)
               `OFF_SERIAL:   serial_reg   <= pwdata;
               `OFF_PROCESS:  process_reg  <= pwdata;
               `OFF_LOOP_MIN: loop_min_reg <= clamp_span(pwdata[15:0]);
               `OFF_LOOP_MAX: loop_max_reg <= clamp_span(pwdata[15:0]);
               `OFF_VEL_MIN:  vel_min_reg  <= pwdata[15:0];
               `OFF_VEL_MAX:  vel_max_reg  <= pwdata[15:0];
               `OFF_THRESH:   thresh_reg   <= pwdata;
               `OFF_WARMUP:   warmup_reg   <= pwdata[15:0];
               default:       thresh_reg   <= thresh_reg;
            endcase
         end
      end
   end

   // read multiplexer
   always @*
   begin
      case (paddr)
         `OFF_SERIAL:   rd_mux = serial_reg;
         `OFF_PROCESS:  rd_mux = process_reg;
         `OFF_LOOP_MIN: rd_mux = {16'h0000, loop_min_reg};
         `OFF_LOOP_MAX: rd_mux = {16'h0000, loop_max_reg};
         `OFF_VEL_MIN:  rd_mux = {16'h0000, vel_min_reg};
         `OFF_VEL_MAX:  rd_mux = {16'h0000, vel_max_reg};
         `OFF_THRESH:   rd_mux = thresh_reg;
         `OFF_WARMUP:   rd_mux = {16'h0000, warmup_reg};
         `OFF_STATUS:   rd_mux = {23'h000000, fill_reg};
         `OFF_SMOOTH:   rd_mux = smooth_reg;
         `OFF_LOOP_OUT: rd_mux = {15'h0000, warm_done_reg, loop_current_ua};
         `OFF_LINK:     rd_mux = {24'h000000, snr_db};
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   // warm-up timer counts milliseconds since reset
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ms_cnt_reg     <= 32'h0000_0000;
         ms_elapsed_reg <= 16'h0000;
         warm_done_reg  <= 1'b0;
      end
      else if (!warm_done_reg)
      begin
         if (ms_cnt_reg == CYCLES_PER_MS - 1)
         begin
            ms_cnt_reg     <= 32'h0000_0000;
            ms_elapsed_reg <= ms_elapsed_reg + 16'h0001;
         end
         else
            ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
         // fast start cuts the wait to one millisecond
         if (ms_elapsed_reg >= warmup_reg || (process_reg[31] && ms_elapsed_reg != 16'h0000))
            warm_done_reg <= 1'b1;
      end
   end

   // sliding average history; one update per accepted reading
   always @(posedge pclk)
   begin
      if (acc_valid)
         hist_mem[wr_ptr_reg] <= vel_acc;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr_reg      <= 8'h00;
         fill_reg        <= 9'h000;
         sum_reg         <= 32'h0000_0000;
         smooth_reg      <= 32'h0000_0000;
         report_valid    <= 1'b0;
         report_velocity <= 32'h0000_0000;
         report_incoming <= 1'b0;
         taps_reg        <= 9'h000;
      end
      else
      begin
         report_valid <= acc_valid;
         taps_reg     <= taps;
         if (acc_valid)
         begin
            wr_ptr_reg <= wr_ptr_reg + 8'h01;
            if (restart)
               fill_reg <= 9'h001;
            else if (fill_reg < taps)
               fill_reg <= fill_reg + 9'h001;
            sum_reg    <= sum_next;
            smooth_reg <= avg_next;
            report_incoming <= meas_incoming;
            // mm/s goes unscaled, other units times ten
            if (unit_sel == 3'h0)
               report_velocity <= avg_next;
            else
               report_velocity <= avg_next * 32'd10;
         end
         else if (restart)
         begin
            fill_reg <= 9'h000;
            sum_reg  <= 32'h0000_0000;
         end
      end
   end

   // current loop scaling; a zero span pins the loop at its low end
   always @*
   begin
      span = {16'h0000, hi_b - lo_b};
      offs = (smooth_reg[15:0] <= lo_b) ? 32'h0000_0000 : {16'h0000, smooth_reg[15:0] - lo_b};
      if (offs > span)
         offs = span;
      if (span == 32'h0000_0000)
         loop_scaled = 32'h0000_0000;
      else
         loop_scaled = (offs * {16'h0000, `LOOP_MAX_UA - `LOOP_MIN_UA}) / span;
   end

   // current loop mapping and serial side outputs
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         loop_current_ua    <= `LOOP_MIN_UA;
         loop_enable        <= 1'b0;
         rx_byte_accept     <= 1'b0;
         answer_enable      <= 1'b0;
         tx_parity          <= 1'b0;
         amplifier_gain_cap <= `GAIN_DEFAULT;
         bit_rate           <= `BAUD_DEFAULT;
         p2p_legacy_protocol <= 1'b0;
         simple_request_response_protocol <= 1'b1;
         stop_bits          <= 2'h1;
         peak_width         <= 4'h0;
         skip_self_config   <= 1'b0;
      end
      else
      begin
         loop_enable <= process_reg[23];
         if (!process_reg[23])
            loop_current_ua <= 16'h0000;
         else
            loop_current_ua <= `LOOP_MIN_UA + loop_scaled[15:0];
         rx_byte_accept <= rx_byte_valid &
            ((parity_sel == `PAR_NONE) || (rx_parity == par_bit(rx_byte, parity_sel)));
         answer_enable <= rx_addr_valid & (rx_addr == slave_id);
         tx_parity <= (parity_sel == `PAR_NONE) ? 1'b0 : par_bit(tx_byte, parity_sel);
         amplifier_gain_cap <= process_reg[19:16];
         bit_rate <= {8'h00, serial_reg[23:0]};
         p2p_legacy_protocol <= process_reg[8];
         simple_request_response_protocol <= ~process_reg[9];
         stop_bits <= process_reg[11:10];
         peak_width <= process_reg[15:12];
         skip_self_config <= process_reg[31];
      end
   end
endmodule // radar_settings
`default_nettype wire

// ### verif/radar_settings_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "radar_settings_defs.vh"
module radar_settings_assertions
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rx_byte_valid,
   input wire logic        rx_byte_accept,
   input wire logic        rx_addr_valid,
   input wire logic        answer_enable,
   input wire logic        meas_valid,
   input wire logic        report_valid,
   input wire logic        loop_enable,
   input wire logic [15:0] loop_current_ua,
   input wire logic [31:0] bit_rate
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // apb transfer steps
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable && pready;
   endsequence
   a_setup_answer: assert property (setup_s |=> access_s)
      else $error("no ready in first access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_accept_cause: assert property (rx_byte_accept |-> $past(rx_byte_valid))
      else $error("byte accepted without a byte");
   a_answer_cause: assert property (answer_enable |-> $past(rx_addr_valid))
      else $error("answer without a request");
   a_report_cause: assert property (report_valid |-> $past(meas_valid))
      else $error("report without a reading");
   a_loop_span: assert property (loop_enable |->
      loop_current_ua >= `LOOP_MIN_UA && loop_current_ua <= `LOOP_MAX_UA)
      else $error("loop current outside span");
   a_rate_by_write: assert property ($changed(bit_rate) |->
      $past(psel && penable && pwrite && pready, 2))
      else $error("bit rate moved without a write");
endmodule // radar_settings_assertions
`default_nettype wire

// ### verif/host_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_master_model
(
   input  wire logic       pclk,
   output var  logic       rx_addr_valid,
   output var  logic [7:0] rx_addr,
   output var  logic       rx_byte_valid,
   output var  logic [7:0] rx_byte,
   output var  logic       rx_parity
);
   // idle lines start quiet
   initial
   begin
      rx_addr_valid = 1'b0;
      rx_addr = 8'h00;
      rx_byte_valid = 1'b0;
      rx_byte = 8'h00;
      rx_parity = 1'b0;
   end
   // request carries the target id as its address
   task automatic send_addr(input logic [7:0] id);
   begin
      @(posedge pclk);
      rx_addr_valid <= 1'b1;
      rx_addr <= id;
      @(posedge pclk);
      rx_addr_valid <= 1'b0;
      rx_addr <= ~id; // released lines do not keep the value
   end
   endtask
   // mode 1 odd, 2 even, else none; bad flips the bit
   task automatic send_byte(input logic [7:0] b, input logic [1:0] mode, input logic bad);
   begin
      @(posedge pclk);
      rx_byte_valid <= 1'b1;
      rx_byte <= b;
      rx_parity <= ((mode == 2'h1) ? ^b : (mode == 2'h2) ? ~^b : 1'b0) ^ bad;
      @(posedge pclk);
      rx_byte_valid <= 1'b0;
      rx_byte <= ~b;
   end
   endtask
endmodule // host_master_model
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "radar_settings_defs.vh"
module tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, bit_rate, report_velocity, rd;
   logic        pready, pslverr, meas_valid = 1'b0, meas_incoming = 1'b0, err;
   logic [15:0] meas_velocity = 16'h0, meas_level = 16'h0, meas_peak = 16'h0;
   logic [15:0] meas_mean = 16'h0, loop_current_ua;
   logic [7:0]  rx_byte, rx_addr, tx_byte = 8'h03;
   logic        rx_byte_valid, rx_parity, rx_addr_valid, rx_byte_accept, answer_enable;
   logic        tx_parity, loop_enable, report_valid, report_incoming, p2p_legacy_protocol;
   logic        simple_request_response_protocol, skip_self_config;
   logic [3:0]  amplifier_gain_cap, peak_width;
   logic [1:0]  stop_bits;
   int          bad_count = 0, checks_done = 0;
   // 100 MHz clock
   always #5 pclk = ~pclk;
   radar_settings #(.CYCLES_PER_MS(10)) radar_settings_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .meas_valid, .meas_velocity,
      .meas_incoming, .meas_level, .meas_peak, .meas_mean, .rx_byte_valid, .rx_byte,
      .rx_parity, .rx_addr, .rx_addr_valid, .rx_byte_accept, .answer_enable, .tx_parity,
      .tx_byte, .amplifier_gain_cap, .loop_current_ua, .loop_enable, .report_velocity,
      .report_valid, .report_incoming, .bit_rate, .p2p_legacy_protocol,
      .simple_request_response_protocol, .stop_bits, .peak_width, .skip_self_config);
   host_master_model host_master_model_i (.pclk, .rx_addr_valid, .rx_addr, .rx_byte_valid,
      .rx_byte, .rx_parity);
   task automatic close_out;
   begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("FAIL at %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // one apb transfer; request held until ready is sampled
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
   begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int i = 0; i <= 20; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
         if (i == 20)
         begin
            bad_count++;
            close_out();
         end
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // registered settings follow one edge after the write lands
      @(posedge pclk);
      #1;
   end
   endtask
   // one reading; report looked at in the cycle it stands
   task automatic meas(input logic [15:0] v, input logic inc, input logic [15:0] lv,
                       input logic [15:0] pk, input logic ev, input logic [31:0] evel);
   begin
      @(posedge pclk);
      meas_valid <= 1'b1;
      meas_velocity <= v;
      meas_incoming <= inc;
      meas_level <= lv;
      meas_peak <= pk;
      meas_mean <= 16'h0064;
      @(posedge pclk);
      meas_valid <= 1'b0;
      #1;
      chk(report_valid, ev);
      if (ev)
         chk(report_velocity, evel);
   end
   endtask
   // main sequence
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(bit_rate, `BAUD_DEFAULT);
      chk(amplifier_gain_cap, 4'h8);
      chk(stop_bits, 2'h1);
      chk(loop_enable, 1'b0);
      chk(tx_parity, 1'b1);
      meas(16'h03E8, 1'b1, 16'hFFFF, 16'hFFFF, 1'b0, 32'h0);
      apb(1'b1, 12'h0FC, 32'h0000_0001);
      chk(err, 1'b1);
      apb(1'b0, `OFF_SERIAL, 32'h0);
      chk(rd, 32'h0000_2580);
      apb(1'b1, `OFF_SERIAL, 32'h2A00_4B00);
      chk(bit_rate, 32'h0000_4B00);
      host_master_model_i.send_addr(8'h2A);
      #1 chk(answer_enable, 1'b1);
      host_master_model_i.send_addr(8'h2B);
      #1 chk(answer_enable, 1'b0);
      @(posedge pclk);
      tx_byte <= 8'h07;
      for (int m = 0; m < 3; m++)
      begin
         apb(1'b1, `OFF_PROCESS, {6'h00, m[1:0], 24'h08_0001});
         chk(tx_parity, m == 1);
         host_master_model_i.send_byte(8'h5A, m[1:0], 1'b1);
         #1 chk(rx_byte_accept, m == 0);
         host_master_model_i.send_byte(8'hA7, m[1:0], 1'b0);
         #1 chk(rx_byte_accept, 1'b1);
      end
      apb(1'b1, `OFF_PROCESS, 32'h8004_5B01);
      chk(p2p_legacy_protocol, 1'b1);
      chk(simple_request_response_protocol, 1'b0);
      chk(stop_bits, 2'h2);
      chk(peak_width, 4'h5);
      chk(amplifier_gain_cap, 4'h4);
      chk(skip_self_config, 1'b1);
      // fast start ends warm-up long before 5000 ms would have run out
      repeat (20) @(posedge pclk);
      apb(1'b1, `OFF_THRESH, 32'h0006_0064);
      apb(1'b1, `OFF_VEL_MAX, 32'h0000_3A98);
      apb(1'b1, `OFF_LOOP_MAX, 32'h0000_3A98);
      apb(1'b1, `OFF_PROCESS, 32'h0288_0001);
      meas(16'h03E8, 1'b1, 16'h0032, 16'h0640, 1'b0, 32'h0);
      meas(16'h03E8, 1'b1, 16'h01F4, 16'h00C8, 1'b0, 32'h0);
      meas(16'h1D4C, 1'b1, 16'h01F4, 16'h0640, 1'b1, 32'h1D4C);
      @(posedge pclk);
      #1 chk(loop_current_ua, 16'd12000);
      apb(1'b1, `OFF_PROCESS, 32'h0688_0001);
      meas(16'h03E8, 1'b0, 16'h01F4, 16'h0640, 1'b0, 32'h0);
      meas(16'h03E8, 1'b1, 16'h01F4, 16'h0640, 1'b1, 32'h03E8);
      chk(report_incoming, 1'b1);
      apb(1'b1, `OFF_VEL_MAX, 32'h0000_07D0);
      meas(16'h0BB8, 1'b1, 16'h01F4, 16'h0640, 1'b0, 32'h0);
      apb(1'b1, `OFF_LOOP_MAX, 32'h0000_4E20);
      apb(1'b0, `OFF_LOOP_MAX, 32'h0);
      chk(rd, 32'h0000_3A98);
      apb(1'b1, `OFF_PROCESS, 32'h0288_0002);
      meas(16'h03E8, 1'b1, 16'h01F4, 16'h0640, 1'b1, 32'h03E8);
      meas(16'h0708, 1'b1, 16'h01F4, 16'h0640, 1'b1, 32'h0578);
      // non-mm/s unit: average of 1800 and 1000 sent times ten
      apb(1'b1, `OFF_PROCESS, 32'h1288_0002);
      meas(16'h03E8, 1'b1, 16'h01F4, 16'h0640, 1'b1, 32'h0000_36B0);
      close_out();
   end
endmodule // tb
bind radar_settings radar_settings_assertions radar_settings_assertions_i (.pclk, .presetn,
   .psel, .penable, .pwrite, .pready, .pslverr, .rx_byte_valid, .rx_byte_accept,
   .rx_addr_valid, .answer_enable, .meas_valid, .report_valid, .loop_enable,
   .loop_current_ua, .bit_rate);
`default_nettype wire
